// ---- hdl/acr_codec_dev.sv ----
// Codec control register bank with its two-wire slave port.
// Assumes the host end drives the clock line and never stretches it.
`timescale 1ns/100ps
module acr_codec_dev #(
  parameter logic [6:0] DEV_ADDR = acr_pkg::DEV_ADDR_DEFAULT
) (
  input  wire logic       sys_clk_i,
  input  wire logic       sys_rst_i,
  acr_link_if.dev         link,
  output logic [3:0]      adc_left_gain_o,
  output logic [3:0]      adc_right_gain_o,
  output logic [3:0]      mic_gain_o,
  output logic            left_src_mic_o,
  output logic            adc_left_en_o,
  output logic            adc_right_en_o,
  output logic            dac_en_o,
  output logic            dac_ref_en_o,
  output logic            in_mono_o,
  output logic [1:0]      deemph_sel_o,
  output logic [7:0]      mix_adc_scale_o,
  output logic [7:0]      mix_dsp_scale_o,
  output logic            out_mono_o,
  output logic            out_inv_right_o,
  output logic [7:0]      bass_gain_o,
  output logic [7:0]      treble_gain_o,
  output logic [7:0]      loud_boost_o,
  output logic [7:0]      loud_mode_o
);
  import acr_pkg::*;

  acr_dev_state_e state_q, state_d;
  logic [3:0]     cnt_q, cnt_d;
  logic [7:0]     sh_q, sh_d;
  logic [7:0]     tx_q, tx_d;
  logic [2:0]     bidx_q, bidx_d;
  logic           rd_mode_q, rd_mode_d;
  logic [15:0]    regnum_q, regnum_d;
  logic [7:0]     dhi_q, dhi_d;
  logic           sda_oe_q, sda_oe_d;
  logic           to_tx_q, to_tx_d;
  logic           txbyte_q, txbyte_d;
  logic           nack_q, nack_d;
  logic           ref_en_q, ref_en_d;
  logic [15:0]    regs_q [NREG];
  logic [15:0]    regs_d [NREG];
  logic           scl_s1_q, scl_s2_q, scl_p_q;
  logic           sda_s1_q, sda_s2_q, sda_p_q;
  logic           scl_rise, scl_fall, start_c, stop_c;
  logic [15:0]    rd_word;
  logic [3:0]     wr_idx;

  // Register readback; unmapped numbers read as zero
  function automatic logic [15:0] reg_read(input logic [15:0] num,
                                           input logic [15:0] r [NREG]);
    logic [3:0] i;
    i = reg_index(num);
    reg_read = (i == IDX_NONE) ? 16'h0000 : r[i[2:0]];
  endfunction

  // Line synchronisers and edge/condition detection
  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      scl_s1_q <= 1'b1;
      scl_s2_q <= 1'b1;
      scl_p_q  <= 1'b1;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
      sda_p_q  <= 1'b1;
    end else begin
      scl_s1_q <= link.scl;
      scl_s2_q <= scl_s1_q;
      scl_p_q  <= scl_s2_q;
      sda_s1_q <= link.sda;
      sda_s2_q <= sda_s1_q;
      sda_p_q  <= sda_s2_q;
    end
  end

  assign scl_rise = scl_s2_q & ~scl_p_q;
  assign scl_fall = ~scl_s2_q & scl_p_q;
  assign start_c  = scl_s2_q & scl_p_q & sda_p_q & ~sda_s2_q;
  assign stop_c   = scl_s2_q & scl_p_q & ~sda_p_q & sda_s2_q;
  assign rd_word  = reg_read(regnum_q, regs_q);
  assign wr_idx   = reg_index(regnum_q);

  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    sh_d      = sh_q;
    tx_d      = tx_q;
    bidx_d    = bidx_q;
    rd_mode_d = rd_mode_q;
    regnum_d  = regnum_q;
    dhi_d     = dhi_q;
    sda_oe_d  = sda_oe_q;
    to_tx_d   = to_tx_q;
    txbyte_d  = txbyte_q;
    nack_d    = nack_q;
    regs_d    = regs_q;
    if (start_c) begin
      state_d  = S_RX;
      cnt_d    = 4'h0;
      bidx_d   = 3'h0;
      sda_oe_d = 1'b0;
    end else if (stop_c) begin
      // A transfer cut short before the last value byte changes nothing
      state_d  = S_IDLE;
      sda_oe_d = 1'b0;
    end else begin
      unique case (state_q)
        S_IDLE: begin
        end
        S_RX: begin
          if (scl_rise) begin
            sh_d  = {sh_q[6:0], sda_s2_q};
            cnt_d = cnt_q + 4'h1;
          end else if (scl_fall && cnt_q == 4'h8) begin
            cnt_d    = 4'h0;
            state_d  = S_ACK;
            sda_oe_d = 1'b1;
            to_tx_d  = 1'b0;
            bidx_d   = bidx_q + 3'h1;
            case (bidx_q)
              3'h0: begin
                if (sh_q[7:1] != DEV_ADDR) begin
                  state_d  = S_IDLE;
                  sda_oe_d = 1'b0;
                end else if (sh_q[0]) begin
                  to_tx_d  = 1'b1;
                  txbyte_d = 1'b0;
                end
              end
              3'h1: begin
                if (sh_q == SUB_WRITE) begin
                  rd_mode_d = 1'b0;
                end else if (sh_q == SUB_READ) begin
                  rd_mode_d = 1'b1;
                end else begin
                  state_d  = S_IDLE;
                  sda_oe_d = 1'b0;
                end
              end
              3'h2: regnum_d[15:8] = sh_q;
              3'h3: regnum_d[7:0]  = sh_q;
              3'h4: begin
                if (rd_mode_q) begin
                  state_d  = S_IDLE;
                  sda_oe_d = 1'b0;
                end else begin
                  dhi_d = sh_q;
                end
              end
              3'h5: begin
                if (rd_mode_q) begin
                  state_d  = S_IDLE;
                  sda_oe_d = 1'b0;
                end else if (wr_idx != IDX_NONE) begin
                  regs_d[wr_idx[2:0]] = {dhi_q, sh_q};
                end
              end
              default: begin
                state_d  = S_IDLE;
                sda_oe_d = 1'b0;
              end
            endcase
          end
        end
        S_ACK: begin
          if (scl_fall) begin
            sda_oe_d = 1'b0;
            state_d  = S_RX;
            if (to_tx_q) begin
              state_d  = S_TX;
              tx_d     = rd_word[15:8];
              sda_oe_d = ~tx_d[7];
              cnt_d    = 4'h0;
            end
          end
        end
        S_TX: begin
          if (scl_fall) begin
            if (cnt_q == 4'h7) begin
              state_d  = S_TXACK;
              sda_oe_d = 1'b0;
            end else begin
              tx_d     = {tx_q[6:0], 1'b0};
              cnt_d    = cnt_q + 4'h1;
              sda_oe_d = ~tx_q[6];
            end
          end
        end
        S_TXACK: begin
          if (scl_rise) begin
            nack_d = sda_s2_q;
          end else if (scl_fall) begin
            if (nack_q) begin
              state_d = S_IDLE;
            end else begin
              state_d  = S_TX;
              txbyte_d = ~txbyte_q;
              tx_d     = txbyte_q ? rd_word[15:8] : rd_word[7:0];
              sda_oe_d = ~tx_d[7];
              cnt_d    = 4'h0;
            end
          end
        end
        default: state_d = S_IDLE;
      endcase
    end
    // Reference runs while the output converter or either input converter is on
    ref_en_d = regs_d[IDX_CONV[2:0]][F_DAC_EN] | regs_d[IDX_CONV[2:0]][F_LADC_EN]
             | regs_d[IDX_CONV[2:0]][F_RADC_EN];
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_q   <= S_IDLE;
      cnt_q     <= 4'h0;
      sh_q      <= 8'h00;
      tx_q      <= 8'h00;
      bidx_q    <= 3'h0;
      rd_mode_q <= 1'b0;
      regnum_q  <= 16'h0000;
      dhi_q     <= 8'h00;
      sda_oe_q  <= 1'b0;
      to_tx_q   <= 1'b0;
      txbyte_q  <= 1'b0;
      nack_q    <= 1'b0;
      ref_en_q  <= 1'b0;
      for (int i = 0; i < NREG; i++) begin
        regs_q[i] <= REG_RESET;
      end
    end else begin
      state_q   <= state_d;
      cnt_q     <= cnt_d;
      sh_q      <= sh_d;
      tx_q      <= tx_d;
      bidx_q    <= bidx_d;
      rd_mode_q <= rd_mode_d;
      regnum_q  <= regnum_d;
      dhi_q     <= dhi_d;
      sda_oe_q  <= sda_oe_d;
      to_tx_q   <= to_tx_d;
      txbyte_q  <= txbyte_d;
      nack_q    <= nack_d;
      ref_en_q  <= ref_en_d;
      regs_q    <= regs_d;
    end
  end

  assign link.dev_sda_o  = 1'b0;
  assign link.dev_sda_oe = sda_oe_q;

  // Field outputs taken straight from the register flops, except dac_ref_en_o, which comes from its own ref_en_q flop
  assign adc_left_gain_o  = regs_q[IDX_CONV[2:0]][F_LGAIN +: 4];
  assign adc_right_gain_o = regs_q[IDX_CONV[2:0]][F_RGAIN +: 4];
  assign mic_gain_o       = regs_q[IDX_CONV[2:0]][F_MGAIN +: 4];
  assign left_src_mic_o   = regs_q[IDX_CONV[2:0]][F_LSRC];
  assign adc_left_en_o    = regs_q[IDX_CONV[2:0]][F_LADC_EN];
  assign adc_right_en_o   = regs_q[IDX_CONV[2:0]][F_RADC_EN];
  assign dac_en_o         = regs_q[IDX_CONV[2:0]][F_DAC_EN];
  assign dac_ref_en_o     = ref_en_q;
  assign in_mono_o        = regs_q[IDX_IN_MODE[2:0]][F_MONO];
  assign deemph_sel_o     = regs_q[IDX_IN_MODE[2:0]][F_DEEMPH +: 2];
  assign mix_adc_scale_o  = regs_q[IDX_MIX_ADC[2:0]][F_HI +: 8];
  assign mix_dsp_scale_o  = regs_q[IDX_MIX_DSP[2:0]][F_HI +: 8];
  assign out_mono_o       = regs_q[IDX_OUT_MODE[2:0]][F_MONO];
  assign out_inv_right_o  = regs_q[IDX_OUT_MODE[2:0]][F_INV_R];
  assign bass_gain_o      = regs_q[IDX_BASS[2:0]][F_HI +: 8];
  assign treble_gain_o    = regs_q[IDX_TREBLE[2:0]][F_HI +: 8];
  assign loud_boost_o     = regs_q[IDX_LOUD[2:0]][F_HI +: 8];
  assign loud_mode_o      = regs_q[IDX_LOUD[2:0]][7:0];

endmodule

// ---- hdl/acr_pkg.sv ----
// Constants, register map and field layout of the codec control register bank.
// Assumes both ends of the serial link are compiled against this package.
package acr_pkg;

  localparam int unsigned     SYS_CLK_HZ       = 200_000_000;
  localparam int unsigned     SCL_HZ           = 100_000;
  localparam int unsigned     QTR_CYC          = SYS_CLK_HZ / (4 * SCL_HZ);

  // Serial address of the codec, value arbitrary
  localparam logic [6:0]      DEV_ADDR_DEFAULT = 7'h3A;
  localparam logic [7:0]      SUB_WRITE        = 8'h6C;
  localparam logic [7:0]      SUB_READ         = 8'h6D;

  localparam int unsigned     NREG             = 8;
  localparam logic [3:0]      IDX_NONE         = 4'h8;
  localparam logic [3:0]      IDX_CONV         = 4'h0;
  localparam logic [3:0]      IDX_MIX_ADC      = 4'h1;
  localparam logic [3:0]      IDX_MIX_DSP      = 4'h2;
  localparam logic [3:0]      IDX_IN_MODE      = 4'h3;
  localparam logic [3:0]      IDX_OUT_MODE     = 4'h4;
  localparam logic [3:0]      IDX_BASS         = 4'h5;
  localparam logic [3:0]      IDX_TREBLE       = 4'h6;
  localparam logic [3:0]      IDX_LOUD         = 4'h7;

  localparam logic [15:0]     ADDR_CONV        = 16'h0000;
  localparam logic [15:0]     ADDR_MIX_ADC     = 16'h0006;
  localparam logic [15:0]     ADDR_MIX_DSP     = 16'h0007;
  localparam logic [15:0]     ADDR_IN_MODE     = 16'h0008;
  localparam logic [15:0]     ADDR_OUT_MODE    = 16'h000E;
  localparam logic [15:0]     ADDR_BASS        = 16'h0014;
  localparam logic [15:0]     ADDR_TREBLE      = 16'h0015;
  localparam logic [15:0]     ADDR_LOUD        = 16'h001E;
  localparam logic [15:0]     REG_RESET        = 16'h0000;

  // Field positions
  localparam int unsigned     F_LGAIN          = 12;
  localparam int unsigned     F_RGAIN          = 8;
  localparam int unsigned     F_MGAIN          = 4;
  localparam int unsigned     F_LSRC           = 3;
  localparam int unsigned     F_LADC_EN        = 2;
  localparam int unsigned     F_RADC_EN        = 1;
  localparam int unsigned     F_DAC_EN         = 0;
  localparam int unsigned     F_MONO           = 15;
  localparam int unsigned     F_INV_R          = 14;
  localparam int unsigned     F_HI             = 8;
  localparam int unsigned     F_DEEMPH         = 0;

  function automatic logic [3:0] reg_index(input logic [15:0] num);
    case (num)
      ADDR_CONV:     reg_index = IDX_CONV;
      ADDR_MIX_ADC:  reg_index = IDX_MIX_ADC;
      ADDR_MIX_DSP:  reg_index = IDX_MIX_DSP;
      ADDR_IN_MODE:  reg_index = IDX_IN_MODE;
      ADDR_OUT_MODE: reg_index = IDX_OUT_MODE;
      ADDR_BASS:     reg_index = IDX_BASS;
      ADDR_TREBLE:   reg_index = IDX_TREBLE;
      ADDR_LOUD:     reg_index = IDX_LOUD;
      default:       reg_index = IDX_NONE;
    endcase
  endfunction

  // Bits that carry a defined field; the rest must be sent as zero
  function automatic logic [15:0] reg_wmask(input logic [3:0] idx);
    case (idx)
      IDX_CONV, IDX_LOUD:   reg_wmask = 16'hFFFF;
      IDX_IN_MODE:          reg_wmask = 16'h8003;
      IDX_OUT_MODE:         reg_wmask = 16'hC000;
      IDX_NONE:             reg_wmask = 16'h0000;
      default:              reg_wmask = 16'hFF00;
    endcase
  endfunction

  typedef enum logic [2:0] {S_IDLE, S_RX, S_ACK, S_TX, S_TXACK} acr_dev_state_e;
  typedef enum logic [1:0] {H_IDLE, H_START, H_BYTE, H_STOP} acr_host_state_e;

endpackage

// ---- hdl/acr_link_if.sv ----
// Two-wire link between the host end and the codec register end.
// Assumes open-drain wiring with pull-ups; levels are resolved here.
`timescale 1ns/100ps
interface acr_link_if;
  logic host_scl_o;
  logic host_scl_oe;
  logic host_sda_o;
  logic host_sda_oe;
  logic dev_sda_o;
  logic dev_sda_oe;
  logic scl;
  logic sda;

  assign scl = ~(host_scl_oe & ~host_scl_o);
  assign sda = ~((host_sda_oe & ~host_sda_o) | (dev_sda_oe & ~dev_sda_o));

  modport host (output host_scl_o, host_scl_oe, host_sda_o, host_sda_oe, input scl, sda);
  modport dev  (output dev_sda_o, dev_sda_oe, input scl, sda);
endinterface

// ---- hdl/acr_codec_host.sv ----
// Host end: runs codec register writes and reads over the two-wire link.
// Assumes the codec end never stretches the clock line.
`timescale 1ns/100ps
module acr_codec_host #(
  parameter logic [6:0]  DEV_ADDR = acr_pkg::DEV_ADDR_DEFAULT,
  parameter int unsigned QTR      = acr_pkg::QTR_CYC,
  parameter bit          KEEP_REF = 1'b1
) (
  input  wire logic                     sys_clk_i,
  input  wire logic                     sys_rst_i,
  acr_link_if.host                      link,
  input  wire logic                     req_i,
  input  wire logic                     write_i,
  input  wire logic [15:0]              reg_num_i,
  input  wire logic [15:0]              wdata_i,
  output logic                          busy_o,
  output logic                          done_o,
  output logic                          nack_o,
  output logic                          tone_over_o,
  output logic [15:0]                   rdata_o
);
  import acr_pkg::*;

  if (QTR < 4) begin : g_chk
    $error("QTR too small for line synchronisers");
  end

  acr_host_state_e state_q, state_d;
  logic [15:0]     qcnt_q, qcnt_d;
  logic [1:0]      ph_q, ph_d;
  logic [3:0]      bit_q, bit_d;
  logic [2:0]      bidx_q, bidx_d;
  logic            wr_q, wr_d;
  logic [15:0]     num_q, num_d;
  logic [15:0]     dat_q, dat_d;
  logic [7:0]      rx_q, rx_d;
  logic            scl_oe_q, scl_oe_d, sda_oe_q, sda_oe_d;
  logic            busy_q, busy_d, done_q, done_d, nack_q, nack_d;
  logic [15:0]     rdata_q, rdata_d;
  logic [7:0]      tone_q [3];
  logic [7:0]      tone_d [3];
  logic            over_q, over_d;
  logic            sda_s1_q, sda_s2_q;
  logic            tick, rxb;
  logic [7:0]      txb;
  logic [15:0]     wval;
  logic signed [10:0] tsum;

  assign tick = (qcnt_q == 16'(QTR - 1));
  assign rxb  = ~wr_q && (bidx_q >= 3'h5);

  // Bytes of one transfer in order
  always_comb begin
    unique case (bidx_q)
      3'h0:    txb = {DEV_ADDR, 1'b0};
      3'h1:    txb = wr_q ? SUB_WRITE : SUB_READ;
      3'h2:    txb = num_q[15:8];
      3'h3:    txb = num_q[7:0];
      3'h4:    txb = wr_q ? dat_q[15:8] : {DEV_ADDR, 1'b1};
      default: txb = dat_q[7:0];
    endcase
  end

  // Reserved bits cleared; an input converter kept on while the output one is off
  always_comb begin
    wval = wdata_i & reg_wmask(reg_index(reg_num_i));
    if (KEEP_REF && reg_index(reg_num_i) == IDX_CONV && !wval[F_DAC_EN]
        && !wval[F_LADC_EN] && !wval[F_RADC_EN]) begin
      wval[F_LADC_EN] = 1'b1;
    end
  end

  // Tone headroom in eighths of a dB, volume taken as 0dB
  always_comb begin
    if ($signed(tone_d[0]) > $signed(tone_d[1])) begin
      tsum = 11'(signed'(tone_d[0])) + 11'({tone_d[2], 1'b0});
    end else begin
      tsum = 11'(signed'(tone_d[1])) + 11'({tone_d[2], 1'b0});
    end
    over_d = (tsum > 11'sd0);
  end

  always_comb begin
    state_d  = state_q;
    qcnt_d   = tick ? 16'h0000 : qcnt_q + 16'h0001;
    ph_d     = ph_q;
    bit_d    = bit_q;
    bidx_d   = bidx_q;
    wr_d     = wr_q;
    num_d    = num_q;
    dat_d    = dat_q;
    rx_d     = rx_q;
    scl_oe_d = scl_oe_q;
    sda_oe_d = sda_oe_q;
    done_d   = 1'b0;
    nack_d   = nack_q;
    rdata_d  = rdata_q;
    tone_d   = tone_q;
    unique case (state_q)
      H_IDLE: begin
        qcnt_d = 16'h0000;
        if (req_i) begin
          state_d = H_START;
          ph_d    = 2'h0;
          bidx_d  = 3'h0;
          wr_d    = write_i;
          num_d   = reg_num_i;
          dat_d   = wval;
          nack_d  = 1'b0;
        end
      end
      H_START: begin
        if (tick) begin
          ph_d = ph_q + 2'h1;
          unique case (ph_q)
            2'h0: sda_oe_d = 1'b0;
            2'h1: scl_oe_d = 1'b0;
            2'h2: sda_oe_d = 1'b1;
            default: begin
              scl_oe_d = 1'b1;
              state_d  = H_BYTE;
              bit_d    = 4'h0;
            end
          endcase
        end
      end
      H_BYTE: begin
        if (tick) begin
          ph_d = ph_q + 2'h1;
          unique case (ph_q)
            2'h0: begin
              if (bit_q < 4'h8) begin
                sda_oe_d = ~rxb & ~txb[3'h7 - bit_q[2:0]];
              end else begin
                sda_oe_d = rxb & (bidx_q == 3'h5);
              end
            end
            2'h1: scl_oe_d = 1'b0;
            2'h2: begin
              if (bit_q < 4'h8) begin
                rx_d = {rx_q[6:0], sda_s2_q};
              end else if (!rxb && sda_s2_q) begin
                nack_d = 1'b1;
              end
            end
            default: begin
              scl_oe_d = 1'b1;
              bit_d    = bit_q + 4'h1;
              if (bit_q == 4'h8) begin
                bit_d  = 4'h0;
                bidx_d = bidx_q + 3'h1;
                if (rxb && bidx_q == 3'h5) rdata_d[15:8] = rx_q;
                if (bidx_q == 3'h6) rdata_d[7:0]  = rx_q;
                if (nack_d || (wr_q && bidx_q == 3'h5) || bidx_q == 3'h6) begin
                  state_d = H_STOP;
                end else if (!wr_q && bidx_q == 3'h3) begin
                  state_d = H_START;
                end
              end
            end
          endcase
        end
      end
      H_STOP: begin
        if (tick) begin
          ph_d = ph_q + 2'h1;
          unique case (ph_q)
            2'h0: sda_oe_d = 1'b1;
            2'h1: scl_oe_d = 1'b0;
            2'h2: sda_oe_d = 1'b0;
            default: begin
              state_d = H_IDLE;
              done_d  = 1'b1;
              if (wr_q && !nack_q) begin
                if (reg_index(num_q) == IDX_BASS)   tone_d[0] = dat_q[15:8];
                if (reg_index(num_q) == IDX_TREBLE) tone_d[1] = dat_q[15:8];
                if (reg_index(num_q) == IDX_LOUD)   tone_d[2] = dat_q[15:8];
              end
            end
          endcase
        end
      end
    endcase
    busy_d = (state_d != H_IDLE);
  end

  always_ff @(posedge sys_clk_i) begin
    if (sys_rst_i) begin
      state_q  <= H_IDLE;
      qcnt_q   <= 16'h0000;
      ph_q     <= 2'h0;
      bit_q    <= 4'h0;
      bidx_q   <= 3'h0;
      wr_q     <= 1'b0;
      num_q    <= 16'h0000;
      dat_q    <= 16'h0000;
      rx_q     <= 8'h00;
      scl_oe_q <= 1'b0;
      sda_oe_q <= 1'b0;
      busy_q   <= 1'b0;
      done_q   <= 1'b0;
      nack_q   <= 1'b0;
      rdata_q  <= 16'h0000;
      tone_q   <= '{8'h00, 8'h00, 8'h00};
      over_q   <= 1'b0;
      sda_s1_q <= 1'b1;
      sda_s2_q <= 1'b1;
    end else begin
      state_q  <= state_d;
      qcnt_q   <= qcnt_d;
      ph_q     <= ph_d;
      bit_q    <= bit_d;
      bidx_q   <= bidx_d;
      wr_q     <= wr_d;
      num_q    <= num_d;
      dat_q    <= dat_d;
      rx_q     <= rx_d;
      scl_oe_q <= scl_oe_d;
      sda_oe_q <= sda_oe_d;
      busy_q   <= busy_d;
      done_q   <= done_d;
      nack_q   <= nack_d;
      rdata_q  <= rdata_d;
      tone_q   <= tone_d;
      over_q   <= over_d;
      sda_s1_q <= link.sda;
      sda_s2_q <= sda_s1_q;
    end
  end

  assign link.host_scl_o  = 1'b0;
  assign link.host_sda_o  = 1'b0;
  assign link.host_scl_oe = scl_oe_q;
  assign link.host_sda_oe = sda_oe_q;
  assign busy_o           = busy_q;
  assign done_o           = done_q;
  assign nack_o           = nack_q;
  assign tone_over_o      = over_q;
  assign rdata_o          = rdata_q;

endmodule

// ---- dv/acr_link_checker.sv ----
// Link assertions for both ends.
// Assumes a quarter period of 8 clocks.
`timescale 1ns/100ps
module acr_link_checker (
  input wire logic sys_clk_i,
  input wire logic sys_rst_i,
  input wire logic host_scl_oe,
  input wire logic host_sda_oe,
  input wire logic dev_sda_oe,
  input wire logic scl,
  input wire logic sda
);
  default clocking @(posedge sys_clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_scl; scl == !host_scl_oe; endproperty
  a_scl: assert property (p_scl) else $error("scl level");
  property p_sda; sda == !(host_sda_oe || dev_sda_oe); endproperty
  a_sda: assert property (p_sda) else $error("sda level");
  property p_rst; $past(sys_rst_i) |-> !(host_scl_oe || host_sda_oe || dev_sda_oe); endproperty
  a_rst: assert property (p_rst) else $error("drive at reset");
  property p_dev; $changed(dev_sda_oe) |-> !scl; endproperty
  a_dev: assert property (p_dev) else $error("codec edge");
  property p_ack; $rose(dev_sda_oe) |-> dev_sda_oe [*8]; endproperty
  a_ack: assert property (p_ack) else $error("short drive");
  property p_start; $fell(sda) && scl |-> !dev_sda_oe; endproperty
  a_start: assert property (p_start) else $error("codec start");
  property p_low; $fell(scl) |-> !scl [*8]; endproperty
  a_low: assert property (p_low) else $error("short low");
  property p_high; $rose(scl) |-> scl [*8]; endproperty
  a_high: assert property (p_high) else $error("short high");
endmodule

// ---- dv/audio_codec_control_registers_tb.sv ----
// Bench for the host and codec ends on one link.
// Assumes a quarter period of 8 clocks.
`timescale 1ns/100ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin bad_count++; \
  $display("wrong value %0t got %h want %h", $time, a, b); end end
module audio_codec_control_registers_tb;
  import acr_pkg::*;
  logic        clk = 0, rst = 1, ab = 0, rq = 0, wr = 0, nk, dn, rf, bz, ov;
  logic [15:0] num = 0, wd = 0, rd, ev [8] = '{default: 16'h0000};
  wire  [15:0] g [8];
  int          bad_count = 0, compares = 0, cyc = 0, seed = 32'h96dd;
  localparam logic [15:0] AD [8] = '{16'h0000, 16'h0006, 16'h0007, 16'h0008, 16'h000E,
    16'h0014, 16'h0015, 16'h001E};
  localparam logic [15:0] MK [8] = '{16'hFFFF, 16'hFF00, 16'hFF00, 16'h8003, 16'hC000,
    16'hFF00, 16'hFF00, 16'hFFFF};
  acr_link_if link ();
  acr_codec_host #(.QTR(8)) u_acr_codec_host (.sys_clk_i(clk), .sys_rst_i(rst | ab),
    .link(link), .req_i(rq), .write_i(wr), .reg_num_i(num), .wdata_i(wd), .busy_o(bz),
    .done_o(dn), .nack_o(nk), .tone_over_o(ov), .rdata_o(rd));
  acr_codec_dev u_acr_codec_dev (.sys_clk_i(clk), .sys_rst_i(rst), .link(link),
    .adc_left_gain_o(g[0][15:12]), .adc_right_gain_o(g[0][11:8]), .mic_gain_o(g[0][7:4]),
    .left_src_mic_o(g[0][3]), .adc_left_en_o(g[0][2]), .adc_right_en_o(g[0][1]),
    .dac_en_o(g[0][0]), .dac_ref_en_o(rf), .in_mono_o(g[3][15]), .deemph_sel_o(g[3][1:0]),
    .mix_adc_scale_o(g[1][15:8]), .mix_dsp_scale_o(g[2][15:8]), .out_mono_o(g[4][15]),
    .out_inv_right_o(g[4][14]), .bass_gain_o(g[5][15:8]), .treble_gain_o(g[6][15:8]),
    .loud_boost_o(g[7][15:8]), .loud_mode_o(g[7][7:0]));
  acr_link_checker u_acr_link_checker (.sys_clk_i(clk), .sys_rst_i(rst),
    .host_scl_oe(link.host_scl_oe), .host_sda_oe(link.host_sda_oe),
    .dev_sda_oe(link.dev_sda_oe), .scl(link.scl), .sda(link.sda));
  function automatic logic [15:0] exp_val(input int j, input logic [15:0] v);
    exp_val = v & MK[j];
    if (j == 0 && exp_val[2:0] == 3'h0) exp_val[2] = 1'b1;
  endfunction
  // Tone headroom in eighths of a dB: bass and treble 8 per dB, loudness 4 per dB
  function automatic logic exp_over(input logic [7:0] b, input logic [7:0] t,
                                    input logic [7:0] l);
    int bb, tt;
    bb = int'($signed(b));
    tt = int'($signed(t));
    exp_over = ((bb > tt ? bb : tt) + 2 * int'(l)) > 0;
  endfunction
  task automatic final_report();
    $display("compares %0d bad %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  task automatic op(input logic w, input logic [15:0] n, input logic [15:0] d, input int cut);
    int k = 0;
    rq <= 1'b1;
    wr <= w;
    num <= n;
    wd <= d;
    @(posedge clk);
    rq <= 1'b0;
    @(posedge clk);
    `CHK(bz, 1'b1)
    if (cut > 0) begin
      repeat (cut) @(posedge clk);
      @(posedge link.scl);
      @(posedge clk);
      ab <= 1'b1;
      repeat (4) @(posedge clk);
      ab <= 1'b0;
    end
    while (cut == 0 && dn !== 1'b1 && k++ < 9000) @(posedge clk);
    if (cut == 0 && dn !== 1'b1) bad_count++;
    repeat (4) @(posedge clk);
    `CHK(nk, 1'b0)
    `CHK(bz, 1'b0)
  endtask
  initial begin
    forever #2.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      bad_count++;
      final_report();
    end
  end
  initial begin
    logic [15:0] v;
    int j;
    repeat (20) @(posedge clk);
    rst <= 1'b0;
    repeat (5) @(posedge clk);
    for (int i = 0; i < 16; i++) begin
      j = i % 8;
      v = i > 7 ? 16'hFFFF : 16'($random(seed));
      ev[j] = exp_val(j, v);
      op(1'b1, AD[j], v, 0);
      `CHK(g[j] & MK[j], ev[j])
      `CHK(rf, |ev[0][2:0])
      `CHK(ov, exp_over(ev[5][15:8], ev[6][15:8], ev[7][15:8]))
      `CHK(rd, i == 0 ? 16'h0000 : ev[(i + 7) % 8])
      op(1'b0, AD[j], 16'h0000, 0);
      `CHK(rd, ev[j])
    end
    op(1'b1, AD[3], 16'h8002, 1290);
    `CHK(g[3] & MK[3], ev[3])
    op(1'b0, AD[3], 16'h0000, 0);
    `CHK(rd, ev[3])
    op(1'b1, 16'h0001, 16'hFFFF, 0);
    op(1'b0, 16'h0001, 16'h0000, 0);
    `CHK(rd, 16'h0000)
    final_report();
  end
endmodule
